// File: design/ecw_regs.sv
// window 1 setup and express capability registers behind an apb slave
`include "ecw_params.svh"

module ecw_regs import ecw_pkg::*; (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic strap_reverse,
   input wire logic strap_hotplug,
   input wire logic pwr_msg_valid,
   input wire logic [7:0] pwr_msg_value,
   input wire logic [1:0] pwr_msg_scale,
   input wire logic [31:0] xlt_addr_in,
   input wire logic [31:0] xlt_base_in,
   output logic [31:0] xlt_addr_out,
   output logic [30:6] win1_base_wmask,
   output logic win1_enable,
   output logic reverse_mode,
   output logic hotplug_enabled
);

   // ****************************************************************
   // strap capture
   // ****************************************************************
   logic [1:0] strap_sync;
   ecw_strap_type strap_st_q;
   ecw_strap_type strap_st_d;
   ecw_mode_type mode_q;
   ecw_mode_type mode_d;
   logic hotplug_q;
   logic hotplug_d;

   ecw_sync #(.W(2)) ecw_sync_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .pin_in({strap_hotplug, strap_reverse}),
      .level_out(strap_sync)
   );

   always_comb begin
      strap_st_d = strap_st_q;
      mode_d = mode_q;
      hotplug_d = hotplug_q;
      case (strap_st_q)
         // synchroniser leaves reset holding zero, so wait until pin levels arrive
         ecw_st_settle: strap_st_d = ecw_st_wait;
         ecw_st_wait: strap_st_d = ecw_st_take;
         ecw_st_take: begin
            mode_d = strap_sync[0] ? ecw_mode_rev : ecw_mode_fwd;
            hotplug_d = strap_sync[1];
            strap_st_d = ecw_st_held;
         end
         ecw_st_held: strap_st_d = ecw_st_held;
         default: strap_st_d = ecw_st_settle;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         strap_st_q <= ecw_st_settle;
         mode_q <= ecw_mode_fwd;
         hotplug_q <= 1'b0;
      end else begin
         strap_st_q <= strap_st_d;
         mode_q <= mode_d;
         hotplug_q <= hotplug_d;
      end
   end

   // ****************************************************************
   // apb decode
   // ****************************************************************
   logic setup_ph;
   logic wr_take;
   logic [31:0] wmask32;

   assign setup_ph = psel && !penable;
   assign wr_take = psel && penable && pready && pwrite;
   assign wmask32 = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

   // ****************************************************************
   // window 1 setup fields
   // ****************************************************************
   logic [1:0] atype_q;
   logic [1:0] atype_d;
   logic pref_q;
   logic pref_d;
   logic [30:6] size_q;
   logic [30:6] size_d;
   logic en_q;
   logic en_d;
   logic [31:0] setup_word;
   logic [31:0] setup_new;

   always_comb begin
      atype_d = atype_q;
      pref_d = pref_q;
      size_d = size_q;
      en_d = en_q;
      setup_new = (setup_word & ~wmask32) | (pwdata & wmask32);
      if (wr_take && paddr == `ECW_OFF_WIN1_PRESET) begin
         if (!setup_new[`ECW_SETUP_ATYPE_HI]) begin
            atype_d = setup_new[`ECW_SETUP_ATYPE_HI:`ECW_SETUP_ATYPE_LO];
         end
         pref_d = setup_new[`ECW_SETUP_PREF_BIT];
         size_d = setup_new[`ECW_SETUP_SIZE_HI:`ECW_SETUP_SIZE_LO];
         en_d = setup_new[`ECW_SETUP_EN_BIT];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         atype_q <= `ECW_ATYPE_32;
         pref_q <= 1'b0;
         size_q <= `ECW_SIZE_RESET;
         en_q <= 1'b0;
      end else begin
         atype_q <= atype_d;
         pref_q <= pref_d;
         size_q <= size_d;
         en_q <= en_d;
      end
   end

   // io selector and reserved bits stay zero
   assign setup_word = {en_q, size_q, 2'h0, pref_q, atype_q, 1'b0};

   // ****************************************************************
   // device capability preset fields and slot power capture
   // ****************************************************************
   logic [2:0] payload_q;
   logic [2:0] payload_d;
   logic [2:0] l0s_q;
   logic [2:0] l0s_d;
   logic [2:0] l1_q;
   logic [2:0] l1_d;
   logic [7:0] pwr_val_q;
   logic [7:0] pwr_val_d;
   logic [1:0] pwr_scale_q;
   logic [1:0] pwr_scale_d;
   logic [31:0] dc_preset_word;
   logic [31:0] dc_new;

   assign dc_preset_word = {20'h00000, l1_q, l0s_q, 3'h0, payload_q};

   always_comb begin
      payload_d = payload_q;
      l0s_d = l0s_q;
      l1_d = l1_q;
      pwr_val_d = pwr_val_q;
      pwr_scale_d = pwr_scale_q;
      dc_new = (dc_preset_word & ~wmask32) | (pwdata & wmask32);
      if (wr_take && paddr == `ECW_OFF_DEVCAP_PRESET) begin
         if (dc_new[`ECW_DC_PAYLOAD_HI:`ECW_DC_PAYLOAD_LO] <= `ECW_PAYLOAD_MAX) begin
            payload_d = dc_new[`ECW_DC_PAYLOAD_HI:`ECW_DC_PAYLOAD_LO];
         end
         l0s_d = dc_new[`ECW_DC_L0S_HI:`ECW_DC_L0S_LO];
         l1_d = dc_new[`ECW_DC_L1_HI:`ECW_DC_L1_LO];
      end
      if (pwr_msg_valid) begin
         pwr_val_d = pwr_msg_value;
         pwr_scale_d = pwr_msg_scale;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         payload_q <= `ECW_PAYLOAD_RESET;
         l0s_q <= `ECW_LAT_RESET;
         l1_q <= `ECW_LAT_RESET;
         pwr_val_q <= `ECW_PWR_VAL_RESET;
         pwr_scale_q <= `ECW_PWR_SCALE_RESET;
      end else begin
         payload_q <= payload_d;
         l0s_q <= l0s_d;
         l1_q <= l1_d;
         pwr_val_q <= pwr_val_d;
         pwr_scale_q <= pwr_scale_d;
      end
   end

   // ****************************************************************
   // read words
   // ****************************************************************
   logic [31:0] cap_word;
   logic [31:0] devcap_word;
   logic [3:0] port_type;
   logic slot_impl;
   logic [2:0] hp_bits;

   assign port_type = (mode_q == ecw_mode_rev) ? `ECW_PORT_REV : `ECW_PORT_FWD;
   assign slot_impl = (mode_q == ecw_mode_rev);
   assign hp_bits = {3{hotplug_q && mode_q == ecw_mode_fwd}};
   assign cap_word = {2'h0, `ECW_INT_MSG_NUM, slot_impl, port_type, `ECW_CAP_VERSION,
                      `ECW_CAP_NEXT, `ECW_CAP_ID};
   assign devcap_word = {4'h0, pwr_scale_q, pwr_val_q, 3'h0, hp_bits, l1_q, l0s_q,
                         `ECW_TAG8, `ECW_PHANTOM, payload_q};

   // ****************************************************************
   // apb answer, one wait state free access phase
   // ****************************************************************
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;

   always_comb begin
      prdata_d = prdata_q;
      pready_d = 1'b0;
      pslverr_d = 1'b0;
      if (setup_ph) begin
         pready_d = 1'b1;
         prdata_d = 32'h00000000;
         case (paddr)
            `ECW_OFF_WIN1_SETUP, `ECW_OFF_WIN1_PRESET: prdata_d = setup_word;
            `ECW_OFF_CAP_HEADER: prdata_d = cap_word;
            `ECW_OFF_DEV_CAP: prdata_d = devcap_word;
            `ECW_OFF_DEVCAP_PRESET: prdata_d = dc_preset_word;
            `ECW_OFF_STRAP_STATUS: begin
               prdata_d = {29'h00000000, strap_st_q == ecw_st_held, hotplug_q,
                           mode_q == ecw_mode_rev};
            end
            default: pslverr_d = 1'b1;
         endcase
         if (pwrite) begin
            prdata_d = 32'h00000000;
         end
      end else if (psel && penable && pready_q) begin
         pslverr_d = 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         prdata_q <= 32'h00000000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ****************************************************************
   // window outputs and address translation
   // ****************************************************************
   logic [30:6] wmask_q;
   logic [30:6] wmask_d;
   logic en_out_q;
   logic [31:0] xlt_q;
   logic [31:0] xlt_d;
   logic [31:0] sub_mask;

   assign sub_mask = {1'b1, size_q, 6'h00};

   always_comb begin
      wmask_d = en_q ? size_q : 25'h0000000;
      xlt_d = xlt_addr_in;
      if (en_q) begin
         xlt_d = (xlt_base_in & sub_mask) | (xlt_addr_in & ~sub_mask);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wmask_q <= 25'h0000000;
         en_out_q <= 1'b0;
         xlt_q <= 32'h00000000;
      end else begin
         wmask_q <= wmask_d;
         en_out_q <= en_q;
         xlt_q <= xlt_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign win1_base_wmask = wmask_q;
   assign win1_enable = en_out_q;
   assign xlt_addr_out = xlt_q;
   assign reverse_mode = (mode_q == ecw_mode_rev);
   assign hotplug_enabled = hotplug_q;

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   sequence s_rd_setup;
      psel && !penable && !pwrite && paddr == `ECW_OFF_WIN1_SETUP;
   endsequence

   sequence s_rd_cap;
      psel && !penable && !pwrite && paddr == `ECW_OFF_CAP_HEADER;
   endsequence

   sequence s_rd_devcap;
      psel && !penable && !pwrite && paddr == `ECW_OFF_DEV_CAP;
   endsequence

   a_setup_low_bits: assert property (s_rd_setup |=> pready && prdata[0] == 1'b0
      && prdata[5:4] == 2'h0)
      else $error("setup read shows io or reserved bit set");

   a_addr_type_legal: assert property (prdata[2] == 1'b0 || !$past(psel)
      || $past(paddr) != `ECW_OFF_WIN1_SETUP)
      else $error("address type field reads a reserved code");

   a_size_mask_base: assert property (##1 win1_base_wmask == (($past(en_q)) ?
      $past(size_q) : 25'h0000000))
      else $error("base write mask does not follow size mask");

   a_enable_readback: assert property (s_rd_setup |=> prdata[31] == win1_enable)
      else $error("enable bit read differs from enable output");

   a_cap_header_id: assert property (s_rd_cap |=> prdata[15:0] == 16'hf010)
      else $error("capability id or next pointer wrong");

   a_port_by_mode: assert property (s_rd_cap |=> prdata[24:20] ==
      (reverse_mode ? 5'h18 : 5'h07))
      else $error("port type or slot bit wrong for mode");

   a_payload_legal: assert property (payload_q <= 3'h5)
      else $error("payload field holds reserved code");

   a_devcap_fixed: assert property (s_rd_devcap |=> prdata[5:3] == 3'h4
      && prdata[17:15] == 3'h0)
      else $error("phantom, tag or reserved bits wrong");

   a_latency_reset: assert property ($fell(rst) |-> l0s_q == 3'h0 && l1_q == 3'h0)
      else $error("latency fields not zero after reset");

   a_hotplug_bits: assert property (s_rd_devcap |=> prdata[14:12] ==
      {3{hotplug_enabled && !reverse_mode}})
      else $error("hot-plug presence bits wrong");

   a_power_capture: assert property (pwr_msg_valid |=> pwr_val_q == $past(pwr_msg_value)
      && pwr_scale_q == $past(pwr_msg_scale))
      else $error("slot power fields not captured");

   a_xlt_substitute: assert property (en_q && $stable(en_q) && $stable(size_q)
      |=> (xlt_addr_out & $past(sub_mask)) == ($past(xlt_base_in) & $past(sub_mask)))
      else $error("translated high bits not from base");

   a_strap_held: assert property (strap_st_q == ecw_st_held ##1 1'b1 |-> $stable(mode_q)
      && $stable(hotplug_q))
      else $error("strap value changed after capture");

   a_apb_one_cycle: assert property (setup_ph |=> pready ##1 !pready)
      else $error("apb answer not exactly one cycle");

endmodule : ecw_regs

// File: design/ecw_params.svh
// offsets, field positions, reset values and fixed codes of the window and capability registers
`ifndef ECW_PARAMS_SVH
`define ECW_PARAMS_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ECW_OFF_WIN1_SETUP 12'h0ac
`define ECW_OFF_CAP_HEADER 12'h0b0
`define ECW_OFF_DEV_CAP 12'h0b4
`define ECW_OFF_WIN1_PRESET 12'h100
`define ECW_OFF_DEVCAP_PRESET 12'h104
`define ECW_OFF_STRAP_STATUS 12'h108

// ****************************************************************
// window 1 setup fields
// ****************************************************************
`define ECW_SETUP_IO_BIT 0
`define ECW_SETUP_ATYPE_LO 1
`define ECW_SETUP_ATYPE_HI 2
`define ECW_SETUP_PREF_BIT 3
`define ECW_SETUP_SIZE_LO 6
`define ECW_SETUP_SIZE_HI 30
`define ECW_SETUP_EN_BIT 31
`define ECW_ATYPE_32 2'h0
`define ECW_ATYPE_64 2'h1
`define ECW_SIZE_RESET 25'h0000000

// ****************************************************************
// capability header fields
// ****************************************************************
`define ECW_CAP_ID 8'h10
`define ECW_CAP_NEXT 8'hf0
`define ECW_CAP_VERSION 4'h1
`define ECW_PORT_FWD 4'h7
`define ECW_PORT_REV 4'h8
`define ECW_INT_MSG_NUM 5'h00

// ****************************************************************
// device capability fields
// ****************************************************************
`define ECW_DC_PAYLOAD_LO 0
`define ECW_DC_PAYLOAD_HI 2
`define ECW_DC_L0S_LO 6
`define ECW_DC_L0S_HI 8
`define ECW_DC_L1_LO 9
`define ECW_DC_L1_HI 11
`define ECW_PAYLOAD_MAX 3'h5
`define ECW_PAYLOAD_RESET 3'h0
`define ECW_LAT_RESET 3'h0
`define ECW_PHANTOM 2'h0
`define ECW_TAG8 1'h1
`define ECW_PWR_VAL_RESET 8'h00
`define ECW_PWR_SCALE_RESET 2'h0

`endif

// File: design/ecw_pkg.sv
// types shared by the window and capability register block
package ecw_pkg;

   typedef enum logic {ecw_mode_fwd, ecw_mode_rev} ecw_mode_type;

   typedef enum logic [1:0] {ecw_st_settle, ecw_st_wait, ecw_st_take, ecw_st_held} ecw_strap_type;

endpackage : ecw_pkg

// File: design/ecw_sync.sv
// two flip-flop synchroniser for pin levels
module ecw_sync #(
   parameter int W = 2
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);

   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] level_q;
   logic [W-1:0] level_d;

   // ****************************************************************
   // one stage pair per bit
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < W; gi++) begin : g_bit
         always_comb begin
            meta_d[gi] = pin_in[gi];
            level_d[gi] = meta_q[gi];
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         meta_q <= '0;
         level_q <= '0;
      end else begin
         meta_q <= meta_d;
         level_q <= level_d;
      end
   end

   assign level_out = level_q;

endmodule : ecw_sync

// File: tb/ecw_regs_bench.sv
// self-checking bench for the window setup and express capability register block
`include "ecw_params.svh"

`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, ex, got); end end

module ecw_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************
   // signals
   // ****************************************
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic strap_reverse = 1'b0;
   logic strap_hotplug = 1'b1;
   logic pwr_msg_valid = 1'b0;
   logic [7:0] pwr_msg_value = 8'h00;
   logic [1:0] pwr_msg_scale = 2'h0;
   logic [31:0] xlt_addr_in = 32'h00000000;
   logic [31:0] xlt_base_in = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [31:0] xlt_addr_out;
   logic [30:6] win1_base_wmask;
   logic win1_enable;
   logic reverse_mode;
   logic hotplug_enabled;
   logic [31:0] rdv;
   logic errv;
   int failures = 0;
   int checks_done = 0;

   always #5 sys_clk = ~sys_clk;

   ecw_regs ecw_regs_inst (
      .sys_clk(sys_clk),
      .rst(rst),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .strap_reverse(strap_reverse),
      .strap_hotplug(strap_hotplug),
      .pwr_msg_valid(pwr_msg_valid),
      .pwr_msg_value(pwr_msg_value),
      .pwr_msg_scale(pwr_msg_scale),
      .xlt_addr_in(xlt_addr_in),
      .xlt_base_in(xlt_base_in),
      .xlt_addr_out(xlt_addr_out),
      .win1_base_wmask(win1_base_wmask),
      .win1_enable(win1_enable),
      .reverse_mode(reverse_mode),
      .hotplug_enabled(hotplug_enabled)
   );

   // ****************************************
   // bus and helper tasks
   // ****************************************
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      pstrb <= 4'hf;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      `CHK("pready wait", 1, n)
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask : apb

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input string nm);
      apb(1'b0, a, 32'h00000000);
      `CHK(nm, ex, rdv)
      `CHK("pslverr", 1'b0, errv)
   endtask : rd_chk

   task automatic do_reset(input logic rev, input logic hp);
      rst <= 1'b1;
      strap_reverse <= rev;
      strap_hotplug <= hp;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (6) @(posedge sys_clk);
   endtask : do_reset

   task automatic pwr(input logic [7:0] v, input logic [1:0] s);
      pwr_msg_valid <= 1'b1;
      pwr_msg_value <= v;
      pwr_msg_scale <= s;
      @(posedge sys_clk);
   endtask : pwr

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset_fwd();
      rd_chk(`ECW_OFF_WIN1_SETUP, 32'h00000000, "setup reset");
      rd_chk(`ECW_OFF_CAP_HEADER, 32'h0071f010, "header fwd");
      rd_chk(`ECW_OFF_DEV_CAP, 32'h00007020, "devcap fwd");
      rd_chk(`ECW_OFF_STRAP_STATUS, 32'h00000006, "strap status");
      `CHK("win1_enable", 1'b0, win1_enable)
      `CHK("hotplug_enabled", 1'b1, hotplug_enabled)
   endtask : t_reset_fwd

   task automatic t_window();
      apb(1'b1, `ECW_OFF_WIN1_PRESET, 32'h8000f03b);
      rd_chk(`ECW_OFF_WIN1_SETUP, 32'h8000f00a, "setup preset");
      `CHK("wmask", 25'h00003c0, win1_base_wmask)
      `CHK("win1_enable", 1'b1, win1_enable)
      apb(1'b1, `ECW_OFF_WIN1_PRESET, 32'h8000f00c);
      rd_chk(`ECW_OFF_WIN1_SETUP, 32'h8000f00a, "type kept");
      apb(1'b1, `ECW_OFF_WIN1_SETUP, 32'h00000000);
      rd_chk(`ECW_OFF_WIN1_SETUP, 32'h8000f00a, "setup read only");
      xlt_addr_in <= 32'h12345678;
      xlt_base_in <= 32'habcdef00;
      repeat (2) @(posedge sys_clk);
      `CHK("xlt on", 32'h9234e678, xlt_addr_out)
      apb(1'b1, `ECW_OFF_WIN1_PRESET, 32'h00000000);
      repeat (2) @(posedge sys_clk);
      `CHK("xlt off", 32'h12345678, xlt_addr_out)
      `CHK("wmask off", 25'h0000000, win1_base_wmask)
      `CHK("win1_enable off", 1'b0, win1_enable)
   endtask : t_window

   task automatic t_devcap();
      apb(1'b1, `ECW_OFF_DEVCAP_PRESET, 32'h00000ec5);
      rd_chk(`ECW_OFF_DEV_CAP, 32'h00007ee5, "devcap preset");
      apb(1'b1, `ECW_OFF_DEVCAP_PRESET, 32'h00000006);
      rd_chk(`ECW_OFF_DEV_CAP, 32'h00007025, "payload kept");
      apb(1'b1, `ECW_OFF_DEV_CAP, 32'hffffffff);
      rd_chk(`ECW_OFF_DEV_CAP, 32'h00007025, "devcap read only");
   endtask : t_devcap

   task automatic t_power();
      pwr(8'ha5, 2'h2);
      pwr_msg_valid <= 1'b0;
      @(posedge sys_clk);
      rd_chk(`ECW_OFF_DEV_CAP, 32'h0a947025, "power single");
      pwr(8'h11, 2'h1);
      pwr(8'h3c, 2'h3);
      pwr_msg_valid <= 1'b0;
      @(posedge sys_clk);
      rd_chk(`ECW_OFF_DEV_CAP, 32'h0cf07025, "power latest");
   endtask : t_power

   task automatic t_unmapped();
      apb(1'b0, 12'h0c0, 32'h00000000);
      `CHK("unmapped rd data", 32'h00000000, rdv)
      `CHK("unmapped rd err", 1'b1, errv)
      apb(1'b1, 12'h0c0, 32'hffffffff);
      `CHK("unmapped wr err", 1'b1, errv)
   endtask : t_unmapped

   task automatic t_reverse();
      do_reset(1'b1, 1'b1);
      rd_chk(`ECW_OFF_CAP_HEADER, 32'h0181f010, "header rev");
      rd_chk(`ECW_OFF_DEV_CAP, 32'h00000020, "devcap rev");
      rd_chk(`ECW_OFF_WIN1_SETUP, 32'h00000000, "setup rev");
      strap_reverse <= 1'b0;
      strap_hotplug <= 1'b0;
      repeat (4) @(posedge sys_clk);
      rd_chk(`ECW_OFF_CAP_HEADER, 32'h0181f010, "straps held");
      `CHK("reverse_mode", 1'b1, reverse_mode)
   endtask : t_reverse

   // ****************************************
   // sequence, watchdog and verdict
   // ****************************************
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : results

   initial begin
      do_reset(1'b0, 1'b1);
      t_reset_fwd();
      t_window();
      t_devcap();
      t_power();
      t_unmapped();
      t_reverse();
      results();
   end

   initial begin
      repeat (3000) @(posedge sys_clk);
      failures++;
      results();
   end

endmodule : ecw_regs_bench
